// file: core/dmr_chain.v
// Function
// - Status read clears pending interrupt flags
// - Handshake select: 1 hardware, 0 software
// - Hardware handshake uses selected peripheral lines
// - Start needs enable write and global enable
// - Acknowledge each transaction until buffer done
// - Dual reload restores addresses, control-A; irq
// - End of chain: complete irq, disable channel
// - Unmasked buffer irq stalls until resume write
// - Masked irq continues; software clears auto
// - List mode ignores descriptor source address
// - Fetch five descriptor words from pointer
// - Write back control-A only, same place
// - Written control-A has length and done
// - List mode restores source, irq, evaluates end
// - Control fields select type, width, layer, step
`timescale 1ns/1ps
`default_nettype none
`include "dmr_map.vh"

module dmr_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = (count_q != DEPTH);
  assign outValid = (count_q != 0);
  assign outData = mem[rdPtr_q];
  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 1'b1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // dmr_fifo

module dmr_chain (
  input wire clk,
  input wire reset_n,
  input wire globalEnable,
  input wire chanEnableWrite,
  input wire resumeChannel,
  input wire irqStatusRead,
  input wire irqUnmasked,
  input wire [31:0] chanSrcAddress,
  input wire [31:0] chanDstAddress,
  input wire [31:0] chanControlA,
  input wire [31:0] chanControlB,
  input wire [31:0] chanDescriptorPointer,
  input wire [31:0] chanConfig,
  input wire [15:0] perSrcReq,
  input wire [15:0] perDstReq,
  input wire swSrcReq,
  input wire swDstReq,
  output reg [15:0] perSrcAck_q,
  output reg [15:0] perDstAck_q,
  output reg swSrcAck_q,
  output reg swDstAck_q,
  output reg memReq_q,
  output reg memWrite_q,
  output reg [31:0] memAddr_q,
  output reg [31:0] memWdata_q,
  output reg [1:0] memLayer_q,
  input wire memAck,
  input wire [31:0] memRdata,
  output reg channelEnabled_q,
  output reg channelPaused_q,
  output reg bufferCompleteIrq_q,
  output reg transferCompleteIrq_q,
  output reg [31:0] curSrcAddr_q,
  output reg [31:0] curDstAddr_q,
  output reg [31:0] curControlA_q,
  output reg [31:0] curDescPtr_q
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_MOVE = 3'h3;
  localparam [2:0] ST_WBACK = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;
  localparam [2:0] ST_PAUSE = 3'h6;

  reg [2:0] state_q;
  reg listMode_q;
  reg [31:0] srcInit_q;
  reg [31:0] dstInit_q;
  reg [31:0] ctlAInit_q;
  reg [31:0] ctlB_q;
  reg [31:0] descAddr_q;
  reg [2:0] fetchIdx_q;
  reg [15:0] rdLeft_q;
  reg [15:0] wrLeft_q;
  reg [15:0] moved_q;
  reg [1:0] opKind_q;
  reg [1:0] descLayer_q;
  reg [15:0] srcS1_q, srcS2_q, srcS3_q, srcF_q;
  reg [15:0] dstS1_q, dstS2_q, dstS3_q, dstF_q;

  // Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srcS1_q <= 16'h0000;
      srcS2_q <= 16'h0000;
      srcS3_q <= 16'h0000;
      srcF_q <= 16'h0000;
      dstS1_q <= 16'h0000;
      dstS2_q <= 16'h0000;
      dstS3_q <= 16'h0000;
      dstF_q <= 16'h0000;
    end else begin
      srcS1_q <= perSrcReq;
      srcS2_q <= srcS1_q;
      srcS3_q <= srcS2_q;
      srcF_q <= (srcS2_q & srcS3_q) | (srcF_q & (srcS2_q | srcS3_q));
      dstS1_q <= perDstReq;
      dstS2_q <= dstS1_q;
      dstS3_q <= dstS2_q;
      dstF_q <= (dstS2_q & dstS3_q) | (dstF_q & (dstS2_q | dstS3_q));
    end
  end

  wire [2:0] fc = ctlB_q[`DMR_FC_HI:`DMR_FC_LO];
  wire srcIsPer = (fc == `DMR_FC_P2M) || (fc == `DMR_FC_P2P);
  wire dstIsPer = (fc == `DMR_FC_M2P) || (fc == `DMR_FC_P2P);
  wire srcHw = chanConfig[`DMR_SHS];
  wire dstHw = chanConfig[`DMR_DHS];
  wire [3:0] srcId = chanConfig[`DMR_SPER_HI:`DMR_SPER_LO];
  wire [3:0] dstId = chanConfig[`DMR_DPER_HI:`DMR_DPER_LO];
  wire srcReady = !srcIsPer || (srcHw ? srcF_q[srcId] : swSrcReq);
  wire dstReady = !dstIsPer || (dstHw ? dstF_q[dstId] : swDstReq);

  wire fifoInReady;
  wire fifoOutValid;
  wire [31:0] fifoOutData;
  wire opDone = memReq_q && memAck;
  wire pushWord = opDone && (opKind_q == `DMR_OP_RD);
  wire canIssue = (state_q == ST_MOVE) && !memReq_q;
  wire issueRd = canIssue && (rdLeft_q != 16'h0000) && fifoInReady && srcReady;
  wire issueWr = canIssue && !issueRd && fifoOutValid && dstReady;

  dmr_fifo #(.WIDTH(32), .DEPTH(8), .AW(3)) dataFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(pushWord),
    .inReady(fifoInReady),
    .inData(memRdata),
    .outValid(fifoOutValid),
    .outReady(issueWr),
    .outData(fifoOutData)
  );

  // Address step from width and step fields
  function [31:0] stepAddr;
    input [31:0] addr;
    input [1:0] mode;
    input [1:0] width;
    reg [31:0] size;
    begin
      size = 32'h0000_0001 << width;
      if (mode == `DMR_STEP_INC) begin
        stepAddr = addr + size;
      end else if (mode == `DMR_STEP_DEC) begin
        stepAddr = addr - size;
      end else begin
        stepAddr = addr;
      end
    end
  endfunction

  wire endOfChain = listMode_q ? (curDescPtr_q[31:2] == 30'h0)
                               : !chanControlB[`DMR_AUTO];
  wire [31:0] fetchAddr = descAddr_q + {27'h0, fetchIdx_q, 2'h0};
  wire [31:0] wbAddr = descAddr_q + {27'h0, `DMR_DESC_CTLA, 2'h0};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      listMode_q <= 1'b0;
      srcInit_q <= 32'h0;
      dstInit_q <= 32'h0;
      ctlAInit_q <= 32'h0;
      ctlB_q <= 32'h0;
      descAddr_q <= 32'h0;
      fetchIdx_q <= 3'h0;
      rdLeft_q <= 16'h0;
      wrLeft_q <= 16'h0;
      moved_q <= 16'h0;
      opKind_q <= `DMR_OP_FETCH;
      descLayer_q <= 2'h0;
      perSrcAck_q <= 16'h0;
      perDstAck_q <= 16'h0;
      swSrcAck_q <= 1'b0;
      swDstAck_q <= 1'b0;
      memReq_q <= 1'b0;
      memWrite_q <= 1'b0;
      memAddr_q <= 32'h0;
      memWdata_q <= 32'h0;
      memLayer_q <= 2'h0;
      channelEnabled_q <= 1'b0;
      channelPaused_q <= 1'b0;
      bufferCompleteIrq_q <= 1'b0;
      transferCompleteIrq_q <= 1'b0;
      curSrcAddr_q <= 32'h0;
      curDstAddr_q <= 32'h0;
      curControlA_q <= 32'h0;
      curDescPtr_q <= 32'h0;
    end else begin
      perSrcAck_q <= 16'h0;
      perDstAck_q <= 16'h0;
      swSrcAck_q <= 1'b0;
      swDstAck_q <= 1'b0;
      if (irqStatusRead) begin
        bufferCompleteIrq_q <= 1'b0;
        transferCompleteIrq_q <= 1'b0;
      end
      if (opDone) begin
        memReq_q <= 1'b0;
      end
      if (!listMode_q) begin
        ctlB_q <= chanControlB;
      end
      case (state_q)
        ST_IDLE: begin
          if (chanEnableWrite && globalEnable) begin
            channelEnabled_q <= 1'b1;
            srcInit_q <= chanSrcAddress;
            dstInit_q <= chanDstAddress;
            ctlAInit_q <= chanControlA;
            ctlB_q <= chanControlB;
            curSrcAddr_q <= chanSrcAddress;
            curDstAddr_q <= chanDstAddress;
            curControlA_q <= chanControlA;
            curDescPtr_q <= chanDescriptorPointer;
            listMode_q <= (chanDescriptorPointer[31:2] != 30'h0);
            if (chanDescriptorPointer[31:2] != 30'h0) begin
              descAddr_q <= {chanDescriptorPointer[31:2], 2'h0};
              descLayer_q <= chanDescriptorPointer[`DMR_DLYR_HI:`DMR_DLYR_LO];
              fetchIdx_q <= 3'h0;
              state_q <= ST_FETCH;
            end else begin
              state_q <= ST_START;
            end
          end
        end
        ST_FETCH: begin
          if (!memReq_q && !opDone) begin
            memReq_q <= 1'b1;
            memWrite_q <= 1'b0;
            memAddr_q <= fetchAddr;
            memLayer_q <= descLayer_q;
            opKind_q <= `DMR_OP_FETCH;
          end
          if (opDone) begin
            case (fetchIdx_q)
              3'h0: curSrcAddr_q <= curSrcAddr_q;
              3'h1: curDstAddr_q <= memRdata;
              3'h2: curDescPtr_q <= memRdata;
              3'h3: curControlA_q <= memRdata;
              default: ctlB_q <= memRdata;
            endcase
            fetchIdx_q <= fetchIdx_q + 3'h1;
            if (fetchIdx_q == `DMR_DESC_LAST) begin
              state_q <= ST_START;
            end
          end
        end
        ST_START: begin
          rdLeft_q <= curControlA_q[`DMR_LEN_HI:`DMR_LEN_LO];
          wrLeft_q <= curControlA_q[`DMR_LEN_HI:`DMR_LEN_LO];
          moved_q <= 16'h0;
          state_q <= ST_MOVE;
        end
        ST_MOVE: begin
          if (issueRd) begin
            memReq_q <= 1'b1;
            memWrite_q <= 1'b0;
            memAddr_q <= curSrcAddr_q;
            memLayer_q <= ctlB_q[`DMR_SLAY_HI:`DMR_SLAY_LO];
            opKind_q <= `DMR_OP_RD;
            rdLeft_q <= rdLeft_q - 16'h1;
          end else if (issueWr) begin
            memReq_q <= 1'b1;
            memWrite_q <= 1'b1;
            memAddr_q <= curDstAddr_q;
            memWdata_q <= fifoOutData;
            memLayer_q <= ctlB_q[`DMR_DLAY_HI:`DMR_DLAY_LO];
            opKind_q <= `DMR_OP_WR;
          end
          if (opDone && opKind_q == `DMR_OP_RD) begin
            curSrcAddr_q <= stepAddr(curSrcAddr_q,
              ctlB_q[`DMR_SSTEP_HI:`DMR_SSTEP_LO],
              curControlA_q[`DMR_SWID_HI:`DMR_SWID_LO]);
            if (srcIsPer && srcHw) begin
              perSrcAck_q[srcId] <= 1'b1;
            end
            swSrcAck_q <= srcIsPer && !srcHw;
          end
          if (opDone && opKind_q == `DMR_OP_WR) begin
            curDstAddr_q <= stepAddr(curDstAddr_q,
              ctlB_q[`DMR_DSTEP_HI:`DMR_DSTEP_LO],
              curControlA_q[`DMR_DWID_HI:`DMR_DWID_LO]);
            if (dstIsPer && dstHw) begin
              perDstAck_q[dstId] <= 1'b1;
            end
            swDstAck_q <= dstIsPer && !dstHw;
            wrLeft_q <= wrLeft_q - 16'h1;
            moved_q <= moved_q + 16'h1;
          end
          if (!memReq_q && wrLeft_q == 16'h0) begin
            curControlA_q[`DMR_LEN_HI:`DMR_LEN_LO] <= moved_q;
            curControlA_q[`DMR_DONE] <= 1'b1;
            state_q <= listMode_q ? ST_WBACK : ST_DONE;
          end
        end
        ST_WBACK: begin
          if (!memReq_q && !opDone) begin
            memReq_q <= 1'b1;
            memWrite_q <= 1'b1;
            memAddr_q <= wbAddr;
            memWdata_q <= curControlA_q;
            memLayer_q <= descLayer_q;
            opKind_q <= `DMR_OP_WB;
          end
          if (opDone) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          bufferCompleteIrq_q <= 1'b1;
          if (listMode_q || chanConfig[`DMR_SREP]) begin
            curSrcAddr_q <= srcInit_q;
          end
          if (!listMode_q && chanConfig[`DMR_DREP]) begin
            curDstAddr_q <= dstInit_q;
          end
          if (!listMode_q) begin
            curControlA_q <= ctlAInit_q;
          end
          if (endOfChain) begin
            transferCompleteIrq_q <= 1'b1;
            channelEnabled_q <= 1'b0;
            state_q <= ST_IDLE;
          end else if (irqUnmasked) begin
            channelPaused_q <= 1'b1;
            state_q <= ST_PAUSE;
          end else begin
            descAddr_q <= {curDescPtr_q[31:2], 2'h0};
            descLayer_q <= curDescPtr_q[`DMR_DLYR_HI:`DMR_DLYR_LO];
            fetchIdx_q <= 3'h0;
            state_q <= listMode_q ? ST_FETCH : ST_START;
          end
        end
        ST_PAUSE: begin
          if (resumeChannel) begin
            channelPaused_q <= 1'b0;
            descAddr_q <= {curDescPtr_q[31:2], 2'h0};
            descLayer_q <= curDescPtr_q[`DMR_DLYR_HI:`DMR_DLYR_LO];
            fetchIdx_q <= 3'h0;
            state_q <= listMode_q ? ST_FETCH : ST_START;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // dmr_chain
`default_nettype wire

// file: pkg/dmr_map.vh
`ifndef DMR_MAP_VH
`define DMR_MAP_VH
// Control-A fields
`define DMR_LEN_HI 15
`define DMR_LEN_LO 0
`define DMR_SWID_HI 25
`define DMR_SWID_LO 24
`define DMR_DWID_HI 29
`define DMR_DWID_LO 28
`define DMR_DONE 31
// Control-B fields
`define DMR_SLAY_HI 1
`define DMR_SLAY_LO 0
`define DMR_DLAY_HI 5
`define DMR_DLAY_LO 4
`define DMR_FC_HI 23
`define DMR_FC_LO 21
`define DMR_SSTEP_HI 25
`define DMR_SSTEP_LO 24
`define DMR_DSTEP_HI 29
`define DMR_DSTEP_LO 28
`define DMR_AUTO 31
// Config fields
`define DMR_SPER_HI 3
`define DMR_SPER_LO 0
`define DMR_DPER_HI 7
`define DMR_DPER_LO 4
`define DMR_SREP 8
`define DMR_SHS 9
`define DMR_DREP 12
`define DMR_DHS 13
// Descriptor pointer layer bits
`define DMR_DLYR_HI 1
`define DMR_DLYR_LO 0
// Last descriptor word index and control-A word index
`define DMR_DESC_LAST 3'h4
`define DMR_DESC_CTLA 3'h3
// Address steps and flow control
`define DMR_STEP_INC 2'h0
`define DMR_STEP_DEC 2'h1
`define DMR_FC_M2P 3'h1
`define DMR_FC_P2M 3'h2
`define DMR_FC_P2P 3'h3
// Bus operation kinds
`define DMR_OP_FETCH 2'h0
`define DMR_OP_RD 2'h1
`define DMR_OP_WR 2'h2
`define DMR_OP_WB 2'h3
`endif

// file: testbench/dmr_chain_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dmr_chain_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic globalEnable,
  input wire logic chanEnableWrite,
  input wire logic resumeChannel,
  input wire logic irqStatusRead,
  input wire logic irqUnmasked,
  input wire logic memReq_q,
  input wire logic memWrite_q,
  input wire logic [31:0] memAddr_q,
  input wire logic [1:0] memLayer_q,
  input wire logic memAck,
  input wire logic swDstAck_q,
  input wire logic channelEnabled_q,
  input wire logic channelPaused_q,
  input wire logic bufferCompleteIrq_q,
  input wire logic transferCompleteIrq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  req_hold_a: assert property (memReq_q && !memAck |=> memReq_q
    && $stable(memAddr_q) && $stable(memWrite_q) && $stable(memLayer_q))
    else $error("bus request changed before ack");
  req_drop_a: assert property (memReq_q && memAck |=> !memReq_q)
    else $error("bus request held after ack");
  pause_cause_a: assert property ($rose(channelPaused_q) |->
    bufferCompleteIrq_q && $past(irqUnmasked))
    else $error("pause without unmasked buffer irq");
  pause_idle_a: assert property (channelPaused_q |-> !memReq_q)
    else $error("bus traffic while paused");
  resume_exit_a: assert property (channelPaused_q && resumeChannel
    |=> !channelPaused_q ##[1:8] memReq_q)
    else $error("resume did not restart the channel");
  chain_end_a: assert property ($fell(channelEnabled_q) |->
    transferCompleteIrq_q && bufferCompleteIrq_q)
    else $error("channel disabled without completion irqs");
  start_gate_a: assert property ($rose(channelEnabled_q) |->
    $past(chanEnableWrite) && $past(globalEnable))
    else $error("channel started without enable and global enable");
  irq_clear_a: assert property (irqStatusRead && !channelEnabled_q
    |=> !bufferCompleteIrq_q && !transferCompleteIrq_q)
    else $error("status read left irq pending");
  ack_cause_a: assert property (swDstAck_q |-> $past(memAck)
    && $past(memWrite_q))
    else $error("handshake ack without completed write");
endmodule // dmr_chain_asserts
`default_nettype wire

// file: testbench/dmr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmr_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic memReq_q,
  input wire logic memWrite_q,
  input wire logic [31:0] memAddr_q,
  input wire logic [31:0] memWdata_q,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] mem [logic [31:0]];
  int gap = 0;
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0;
  end
  // Answers each transfer after a random gap; stale read data is inverted
  always @(posedge clk) begin
    if (!reset_n || memAck || !memReq_q) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end else if (gap > 0) begin
      gap <= gap - 1;
    end else begin
      memAck <= 1'b1;
      gap <= $urandom_range(2);
      if (memWrite_q) mem[memAddr_q] = memWdata_q;
      memRdata <= mem.exists(memAddr_q) ? mem[memAddr_q] : ~memAddr_q;
    end
  end
endmodule // dmr_mem_model
`default_nettype wire

// file: testbench/dmr_chain_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmr_chain_tb_top;
  logic clk = 0, reset_n = 0, globalEnable = 0, chanEnableWrite = 0;
  logic resumeChannel = 0, irqStatusRead = 0, irqUnmasked = 0;
  logic [31:0] chanSrcAddress = 0, chanDstAddress = 0, chanControlA = 0;
  logic [31:0] chanControlB = 0, chanDescriptorPointer = 0, chanConfig = 0;
  logic swSrcReq = 0, swDstReq = 0, swSrcAck_q, swDstAck_q;
  logic memReq_q, memWrite_q, memAck;
  logic [15:0] perSrcReq = 0, perDstReq = 0, perSrcAck_q, perDstAck_q;
  logic [31:0] memAddr_q, memWdata_q, memRdata, curSrcAddr_q, curDstAddr_q;
  logic [31:0] curControlA_q, curDescPtr_q;
  logic [1:0] memLayer_q;
  logic channelEnabled_q, channelPaused_q;
  logic bufferCompleteIrq_q, transferCompleteIrq_q;
  int failures = 0, check_count = 0, acks = 0, srcAcks = 0;
  int hwSrcAcks = 0, hwDstAcks = 0;
  logic [65:0] expQ[$];
  logic [65:0] expWr;
  logic [31:0] srcData[4];

  dmr_chain dut (.clk(clk), .reset_n(reset_n), .globalEnable(globalEnable),
    .chanEnableWrite(chanEnableWrite), .resumeChannel(resumeChannel),
    .irqStatusRead(irqStatusRead), .irqUnmasked(irqUnmasked),
    .chanSrcAddress(chanSrcAddress), .chanDstAddress(chanDstAddress),
    .chanControlA(chanControlA), .chanControlB(chanControlB),
    .chanDescriptorPointer(chanDescriptorPointer), .chanConfig(chanConfig),
    .perSrcReq(perSrcReq), .perDstReq(perDstReq), .swSrcReq(swSrcReq),
    .swDstReq(swDstReq), .perSrcAck_q(perSrcAck_q),
    .perDstAck_q(perDstAck_q), .swSrcAck_q(swSrcAck_q),
    .swDstAck_q(swDstAck_q), .memReq_q(memReq_q), .memWrite_q(memWrite_q),
    .memAddr_q(memAddr_q), .memWdata_q(memWdata_q), .memLayer_q(memLayer_q),
    .memAck(memAck), .memRdata(memRdata),
    .channelEnabled_q(channelEnabled_q), .channelPaused_q(channelPaused_q),
    .bufferCompleteIrq_q(bufferCompleteIrq_q),
    .transferCompleteIrq_q(transferCompleteIrq_q),
    .curSrcAddr_q(curSrcAddr_q), .curDstAddr_q(curDstAddr_q),
    .curControlA_q(curControlA_q), .curDescPtr_q(curDescPtr_q));
  dmr_mem_model mdl (.clk(clk), .reset_n(reset_n), .memReq_q(memReq_q),
    .memWrite_q(memWrite_q), .memAddr_q(memAddr_q),
    .memWdata_q(memWdata_q), .memAck(memAck), .memRdata(memRdata));

  always #5 clk = ~clk;

  task automatic report_and_stop;
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [65:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t bus write got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) cmp_val(32'(s), 32'(v), "wait timed out");
  endtask
  task automatic exp_buf(input logic [31:0] dst, int n, logic [1:0] ly);
    for (int i = 0; i < n; i++)
      expQ.push_back({ly, dst + 32'(4 * i), srcData[i]});
  endtask
  // Descriptor: ignored source, destination, next, control-A, control-B
  // Data writes go on layer 2, source reads on layer 0, descriptor traffic on the pointer's layer 1
  task automatic load_desc(input logic [31:0] b, dst, nxt);
    mdl.mem[b] = 32'hbad00000;
    mdl.mem[b + 4] = dst;
    mdl.mem[b + 8] = nxt;
    mdl.mem[b + 12] = 32'h22000002;
    mdl.mem[b + 16] = 32'h00000020;
    exp_buf(dst, 2, 2'h2);
    expQ.push_back({2'h1, b + 32'hc, 32'ha2000002});
  endtask

  always @(posedge clk) begin
    if (swSrcAck_q === 1'b1) srcAcks++;
    if (swDstAck_q === 1'b1) acks++;
    if (perSrcAck_q === 16'h0004) hwSrcAcks++;
    if (perDstAck_q === 16'h0020) hwDstAcks++;
    if (memReq_q && memAck && memWrite_q) begin
      expWr = expQ.size() > 0 ? expQ.pop_front() : '1;
      cmp_wr({memLayer_q, memAddr_q, memWdata_q}, expWr);
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    cmp_val(32'h1, 32'h0, "watchdog expired");
    report_and_stop;
  end

  initial begin
    void'($urandom(83116));
    for (int i = 0; i < 4; i++) begin
      srcData[i] = $urandom;
      mdl.mem[32'h1000 + 32'(4 * i)] = srcData[i];
    end
    repeat (6) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    // Both addresses reload, software handshake at both ends, stall on
    chanSrcAddress = 32'h00001000;
    chanDstAddress = 32'h00002000;
    chanControlA = 32'h22000003;
    chanControlB = 32'h80600000;
    chanConfig = 32'h00001100;
    irqUnmasked = 1'b1;
    globalEnable = 1'b1;
    swSrcReq = 1'b1;
    swDstReq = 1'b1;
    exp_buf(32'h2000, 3, 2'h0);
    pulse(chanEnableWrite);
    wait_for(channelPaused_q, 1'b1);
    cmp_val(curSrcAddr_q, 32'h1000, "source reload");
    cmp_val(curDstAddr_q, 32'h2000, "destination reload");
    cmp_val(curControlA_q, 32'h22000003, "control reload");
    cmp_val(32'(bufferCompleteIrq_q), 1, "buffer irq");
    cmp_val(srcAcks, 3, "source acks at pause");
    pulse(irqStatusRead);
    cmp_val(32'(bufferCompleteIrq_q), 0, "irq clear");
    chanControlB = 32'h00600000;
    exp_buf(32'h2000, 3, 2'h0);
    pulse(resumeChannel);
    wait_for(channelEnabled_q, 1'b0);
    cmp_val(32'(transferCompleteIrq_q), 1, "transfer irq");
    cmp_val(acks, 6, "destination acks");
    cmp_val(srcAcks, 6, "source acks");
    pulse(irqStatusRead);
    // Refused start, then destination list with masked buffer irq
    globalEnable = 1'b0;
    pulse(chanEnableWrite);
    repeat (2) @(negedge clk);
    cmp_val(32'(channelEnabled_q), 0, "start without global");
    load_desc(32'h100, 32'h3000, 32'h201);
    load_desc(32'h200, 32'h3400, 32'h0);
    chanDescriptorPointer = 32'h101;
    chanConfig = 32'h00000100;
    irqUnmasked = 1'b0;
    globalEnable = 1'b1;
    pulse(chanEnableWrite);
    wait_for(channelEnabled_q, 1'b0);
    cmp_val(32'(transferCompleteIrq_q), 1, "list end irq");
    cmp_val(curSrcAddr_q, 32'h1000, "source restored");
    cmp_val(mdl.mem[32'h10c], 32'ha2000002, "done flag");
    cmp_val(expQ.size(), 0, "writes missing");
    cmp_val(curDescPtr_q, 32'h0, "last next pointer");
    pulse(irqStatusRead);
    cmp_val(32'(transferCompleteIrq_q), 0, "list irq clear");
    // Single buffer without address reload, hardware handshake on source 2, destination 5
    perSrcReq = 16'h0004;
    perDstReq = 16'h0020;
    chanDstAddress = 32'h00002100;
    chanControlA = 32'h22000002;
    chanControlB = 32'h00600000;
    chanDescriptorPointer = 32'h0;
    chanConfig = 32'h00002252;
    exp_buf(32'h2100, 2, 2'h0);
    pulse(chanEnableWrite);
    wait_for(channelEnabled_q, 1'b0);
    cmp_val(hwSrcAcks, 2, "source line acks");
    cmp_val(hwDstAcks, 2, "destination line acks");
    cmp_val(acks + srcAcks, 12, "software acks in hardware mode");
    cmp_val(expQ.size(), 0, "handshake writes missing");
    report_and_stop;
  end
endmodule // dmr_chain_tb_top

bind dmr_chain dmr_chain_asserts chk (.clk(clk), .reset_n(reset_n),
  .globalEnable(globalEnable), .chanEnableWrite(chanEnableWrite),
  .resumeChannel(resumeChannel), .irqStatusRead(irqStatusRead),
  .irqUnmasked(irqUnmasked), .memReq_q(memReq_q),
  .memWrite_q(memWrite_q), .memAddr_q(memAddr_q),
  .memLayer_q(memLayer_q), .memAck(memAck), .swDstAck_q(swDstAck_q),
  .channelEnabled_q(channelEnabled_q), .channelPaused_q(channelPaused_q),
  .bufferCompleteIrq_q(bufferCompleteIrq_q),
  .transferCompleteIrq_q(transferCompleteIrq_q));
`default_nettype wire
